// file: design/qsld_driver.sv
/*
 * quadplex segment glass driver: update sequencer, two display
 * memories, glyph write port and pin drive for two ports.
 * assumes external half-supply bias on the common lines and a host
 * that pulses the glyph write for one cycle per character.
 */
`timescale 1ns/1ns
module qsld_driver #(
    parameter int P_NUM_COMMON = qsld_pkg::DEF_NUM_COMMON,
    parameter int P_NUM_SEGMENT = qsld_pkg::DEF_NUM_SEGMENT,
    parameter logic [31:0] P_LOWER_MASK = qsld_pkg::DEF_LOWER_MASK,
    parameter logic [31:0] P_UPPER_MASK = qsld_pkg::DEF_UPPER_MASK,
    parameter int P_SPLIT = qsld_pkg::DEF_SPLIT,
    parameter int P_TICK_CYCLES = qsld_pkg::TICK_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_glyph_write,
    input wire logic [qsld_pkg::GLYPH_IDX_W-1:0] i_glyph_index,
    input wire logic [qsld_pkg::POS_IDX_W-1:0] i_position_index,
    output logic [P_NUM_COMMON-1:0] o_common_line,
    output logic [P_NUM_COMMON-1:0] o_common_line_oe_n,
    output logic [qsld_pkg::PORT_W-1:0] o_segment_line_lower,
    output logic [qsld_pkg::PORT_W-1:0] o_segment_line_lower_oe_n,
    output logic [qsld_pkg::PORT_W-1:0] o_segment_line_upper,
    output logic [qsld_pkg::PORT_W-1:0] o_segment_line_upper_oe_n
);
    import qsld_pkg::*;

    localparam int NUM_POS = P_NUM_SEGMENT / 2; // two segments each

    logic refresh_tick; // one-cycle update tick
    qsld_state_e state; // sequencer state
    qsld_state_e next_state; // state after the next tick
    // display memories: one port word per common line
    logic [PORT_W-1:0] lower_display_memory [P_NUM_COMMON];
    logic [PORT_W-1:0] upper_display_memory [P_NUM_COMMON];

    // tick generator at eight times the refresh rate
    qsld_tick_div #(
        .P_CYCLES(P_TICK_CYCLES)
    ) u_tick_div (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .o_tick(refresh_tick)
    );

    // sequencer decode
    wire [1:0] next_index; // active common after the tick
    wire next_odd; // high half of the common's pair
    wire [P_NUM_COMMON-1:0] next_sel; // one-hot active common
    assign next_state = qsld_state_e'(state + 3'h1);
    assign next_index = next_state[2:1];
    assign next_odd = next_state[0];
    assign next_sel = {{(P_NUM_COMMON-1){1'b0}}, 1'b1} << next_index;
    wire [1:0] cur_index; // common of the present state
    assign cur_index = state[2:1];

    // glyph write decode
    wire [GLYPH_W-1:0] write_pattern; // crosses of the glyph
    wire [OFFSET_W-1:0] write_offset; // first segment pin
    wire [OFFSET_W-1:0] write_offset2; // adjacent second segment pin
    wire write_upper; // position lies on the upper port
    wire write_valid; // write to an existing position
    assign write_pattern = qsld_glyph(i_glyph_index);
    assign write_offset = qsld_position(i_position_index);
    assign write_offset2 = write_offset + 5'h01;
    assign write_upper = 32'(i_position_index) >= P_SPLIT;
    assign write_valid = i_glyph_write
        && (32'(i_position_index) < NUM_POS);

    // segment levels for the next state
    wire [PORT_W-1:0] next_lower; // lower port after the tick
    wire [PORT_W-1:0] next_upper; // upper port after the tick
    assign next_lower = next_odd
        ? (~o_segment_line_lower & P_LOWER_MASK)
        : (lower_display_memory[next_index] & P_LOWER_MASK);
    assign next_upper = next_odd
        ? (~o_segment_line_upper & P_UPPER_MASK)
        : (upper_display_memory[next_index] & P_UPPER_MASK);

    // display memory: written at any time, independent of the tick
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            for (int c = 0; c < P_NUM_COMMON; c++) begin
                lower_display_memory[c] <= '0;
                upper_display_memory[c] <= '0;
            end
        end else if (write_valid) begin
            for (int c = 0; c < P_NUM_COMMON; c++) begin
                // bit c of a nibble belongs to common c
                if (write_upper) begin
                    upper_display_memory[c][write_offset] <=
                        write_pattern[NIBBLE_W + c];
                    upper_display_memory[c][write_offset2] <=
                        write_pattern[c];
                end else begin
                    lower_display_memory[c][write_offset] <=
                        write_pattern[NIBBLE_W + c];
                    lower_display_memory[c][write_offset2] <=
                        write_pattern[c];
                end
            end
        end
    end

    // sequencer and pin drive, updated once per tick
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            // last state, so the first tick starts common 0 low
            state <= ST_COM3_HIGH;
            o_common_line <= '0;
            o_common_line_oe_n <= '1;
            o_segment_line_lower <= '0;
            o_segment_line_upper <= '0;
            o_segment_line_lower_oe_n <= '1;
            o_segment_line_upper_oe_n <= '1;
        end else if (refresh_tick) begin
            state <= next_state;
            o_common_line_oe_n <= ~next_sel;
            o_common_line <= next_odd ? next_sel : '0;
            o_segment_line_lower <= next_lower;
            o_segment_line_upper <= next_upper;
            o_segment_line_lower_oe_n <= ~P_LOWER_MASK;
            o_segment_line_upper_oe_n <= ~P_UPPER_MASK;
        end
    end

    // checks on the sequencer and the pins
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // a tick entering an even or odd state
    sequence seq_tick_even;
        refresh_tick && !next_odd;
    endsequence
    sequence seq_tick_odd;
        refresh_tick && next_odd;
    endsequence
    // an even tick with the write port quiet in the same cycle
    sequence seq_quiet_even;
        seq_tick_even ##0 !i_glyph_write;
    endsequence

    AST_STATE_HOLD: assert property (
        !refresh_tick |=> $stable(state))
        else $error("state moved without a tick");
    AST_STATE_WRAP: assert property (
        refresh_tick && state == ST_COM3_HIGH |=> state == ST_COM0_LOW)
        else $error("sequencer did not wrap to zero");
    AST_STATE_STEP: assert property (
        refresh_tick |=> state == qsld_state_e'($past(state) + 3'h1))
        else $error("sequencer did not step by one");
    AST_EVEN_COMMON: assert property (
        seq_tick_even |=> o_common_line == '0
            && o_common_line_oe_n == ~$past(next_sel))
        else $error("even state common drive wrong");
    AST_ODD_COMMON: assert property (
        seq_tick_odd |=> o_common_line == $past(next_sel)
            && o_common_line_oe_n == ~$past(next_sel))
        else $error("odd state common not high");
    AST_ODD_INVERT: assert property (
        seq_tick_odd |=> o_segment_line_lower ==
            (~$past(o_segment_line_lower) & P_LOWER_MASK))
        else $error("odd state segments not inverted");
    AST_EVEN_SEGMENT: assert property (
        seq_quiet_even |=> o_segment_line_upper ==
            (upper_display_memory[cur_index] & P_UPPER_MASK))
        else $error("even state segments differ from memory");
    AST_MASK_ONLY: assert property (
        (o_segment_line_lower & ~P_LOWER_MASK) == '0
            && (o_segment_line_upper & ~P_UPPER_MASK) == '0)
        else $error("unmasked segment pin driven");
    AST_WRITE_LOWER: assert property (
        write_valid && !write_upper |=>
            lower_display_memory[0][$past(write_offset)]
                == $past(write_pattern[NIBBLE_W]))
        else $error("lower memory write lost");
    AST_WRITE_UPPER: assert property (
        write_valid && write_upper |=>
            upper_display_memory[P_NUM_COMMON-1][$past(write_offset2)]
                == $past(write_pattern[P_NUM_COMMON-1]))
        else $error("upper memory write lost");

    // odd tick flips every masked upper segment pin of the previous state
    AST_ODD_INVERT_UPPER: assert property (
        seq_tick_odd |=> o_segment_line_upper ==
            (~$past(o_segment_line_upper) & P_UPPER_MASK))
        else $error("odd state upper segments not inverted");
    // lower port mirrors its memory word after a quiet even tick
    AST_EVEN_SEGMENT_LOWER: assert property (
        seq_quiet_even |=> o_segment_line_lower ==
            (lower_display_memory[cur_index] & P_LOWER_MASK))
        else $error("even state lower segments differ from memory");
    // the common left behind by an even tick is floated
    AST_PREV_FLOAT: assert property (
        seq_tick_even |=> o_common_line_oe_n[$past(cur_index)] == 1'b1)
        else $error("previous common still driven");
    // after any tick only the masked segment pins are enabled
    AST_SEG_ENABLE: assert property (
        refresh_tick |=> o_segment_line_lower_oe_n == ~P_LOWER_MASK
            && o_segment_line_upper_oe_n == ~P_UPPER_MASK)
        else $error("segment enables differ from the pin masks");
    // a write to a missing position leaves the common 0 word of both memories alone
    AST_REFUSE_WRITE: assert property (
        i_glyph_write && !write_valid |=> $stable(upper_display_memory[0])
            && $stable(lower_display_memory[0]))
        else $error("write to a missing position changed memory");
    // first pin of a position takes the high nibble, msb to common 3
    AST_NIBBLE_ORDER: assert property (
        write_valid && write_upper |=>
            upper_display_memory[P_NUM_COMMON-1][$past(write_offset)]
                == $past(write_pattern[GLYPH_W-1]))
        else $error("glyph nibble order wrong");
endmodule // qsld_driver

// file: design/qsld_pkg.sv
/*
 * constants, sequencer states and lookup tables for the quadplex
 * segment glass driver.
 * assumes a single 50 MHz system clock and a synchronous reset.
 */
package qsld_pkg;

    // system clock and refresh timing
    localparam int CLOCK_HZ = 50_000_000;   // system clock rate
    localparam int REFRESH_HZ = 30;         // full display refresh rate
    localparam int TICKS_PER_REFRESH = 8;   // update ticks per refresh
    localparam int TICK_HZ = REFRESH_HZ * TICKS_PER_REFRESH;
    localparam int TICK_CYCLES = CLOCK_HZ / TICK_HZ; // clocks per tick

    // port and table widths
    localparam int PORT_W = 32;             // pins per port
    localparam int OFFSET_W = 5;            // pin offset within a port
    localparam int GLYPH_IDX_W = 4;         // glyph index width
    localparam int POS_IDX_W = 4;           // position index width
    localparam int GLYPH_W = 8;             // two segment nibbles
    localparam int NIBBLE_W = 4;            // one bit per common line

    // default configuration
    localparam int DEF_NUM_COMMON = 4;      // common lines
    localparam int DEF_NUM_SEGMENT = 16;    // segment lines
    localparam int DEF_SPLIT = 4;           // first upper-port position
    localparam logic [PORT_W-1:0] DEF_LOWER_MASK = 32'h000000FF;
    localparam logic [PORT_W-1:0] DEF_UPPER_MASK = 32'h000000FF;

    // sequencer: common index is state / 2, odd states drive high
    typedef enum logic [2:0] {
        ST_COM0_LOW = 3'b000,
        ST_COM0_HIGH = 3'b001,
        ST_COM1_LOW = 3'b010,
        ST_COM1_HIGH = 3'b011,
        ST_COM2_LOW = 3'b100,
        ST_COM2_HIGH = 3'b101,
        ST_COM3_LOW = 3'b110,
        ST_COM3_HIGH = 3'b111
    } qsld_state_e;

    // glyph table: high nibble is the first segment, msb is common 3
    function automatic logic [GLYPH_W-1:0] qsld_glyph(
        input logic [GLYPH_IDX_W-1:0] idx);
        case (idx)
            4'h0: qsld_glyph = 8'hEB;
            4'h1: qsld_glyph = 8'h60;
            4'h2: qsld_glyph = 8'hC7;
            4'h3: qsld_glyph = 8'hE5;
            4'h4: qsld_glyph = 8'h6C;
            4'h5: qsld_glyph = 8'hAD;
            4'h6: qsld_glyph = 8'hAF;
            4'h7: qsld_glyph = 8'hE0;
            4'h8: qsld_glyph = 8'hEF;
            4'h9: qsld_glyph = 8'hED;
            default: qsld_glyph = 8'h00;
        endcase
    endfunction

    // position table: pin offset of a position's first segment
    function automatic logic [OFFSET_W-1:0] qsld_position(
        input logic [POS_IDX_W-1:0] pos);
        case (pos)
            4'h0: qsld_position = 5'h00;
            4'h1: qsld_position = 5'h02;
            4'h2: qsld_position = 5'h04;
            4'h3: qsld_position = 5'h06;
            4'h4: qsld_position = 5'h00;
            4'h5: qsld_position = 5'h02;
            4'h6: qsld_position = 5'h04;
            4'h7: qsld_position = 5'h06;
            default: qsld_position = 5'h00;
        endcase
    endfunction

endpackage

// file: design/qsld_tick_div.sv
/*
 * divider that turns the system clock into a one-cycle update tick.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module qsld_tick_div #(
    parameter int P_CYCLES = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    output logic o_tick
);
    logic [31:0] count; // cycles since last tick

    // count up and pulse once per period
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            count <= 32'h00000000;
            o_tick <= 1'b0;
        end else if (count == 32'(P_CYCLES - 1)) begin
            count <= 32'h00000000;
            o_tick <= 1'b1;
        end else begin
            count <= count + 32'h00000001;
            o_tick <= 1'b0;
        end
    end
endmodule // qsld_tick_div

// file: tb/qsld_glass.sv
/*
 * passive quadplex glass model: records which crosses see a voltage.
 * assumes the driver pins and a half-supply bias on floated commons.
 */
`timescale 1ns/1ns
module qsld_glass (
    input wire logic i_clock,
    input wire logic [3:0] i_common,
    input wire logic [3:0] i_common_oe_n,
    input wire logic [15:0] i_segment,
    input wire logic [15:0] i_segment_oe_n,
    output logic [15:0] o_dark [4]
);
    // a floated common rests at bias, so its crosses keep their record
    always @(posedge i_clock) begin
        for (int c = 0; c < 4; c++) begin
            if (i_common_oe_n[c] == 1'b0) begin
                // driven segment opposite its common is dark
                o_dark[c] <= (i_segment ^ {16{i_common[c]}})
                    & ~i_segment_oe_n;
            end
        end
    end
endmodule // qsld_glass

// file: tb/qsld_driver_tb.sv
/*
 * self-checking bench for the quadplex glass driver.
 * assumes default masks, split and position table, a short tick.
 */
`timescale 1ns/1ns
module qsld_driver_tb;
    import qsld_pkg::*;
    localparam int TK = 4; // shortened tick period in clocks
    localparam logic [31:0] MSK = 32'h000000FF; // segment pins
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic wr = 1'b0; // glyph write strobe
    logic [3:0] gi = 4'h0; // glyph index
    logic [3:0] pi = 4'h0; // position index
    logic [3:0] com, com_oe_n;
    logic [31:0] lo, lo_oe_n, hi, hi_oe_n;
    logic [15:0] dark [4]; // crosses seen dark by the glass
    logic [31:0] exp_lo [4], exp_hi [4]; // expected memories
    logic [2:0] st, prev_st; // observed sequencer state
    logic [31:0] ex_lo, ex_hi; // expected segment pins this cycle
    logic [15:0] lfsr = 16'h2E36; // random source
    logic chk = 1'b0, seen = 1'b0;
    int since = 0, err_total = 0, n_tests = 0;
    always #10 i_clock = ~i_clock;
    qsld_driver #(.P_TICK_CYCLES(TK)) DUT (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_glyph_write(wr), .i_glyph_index(gi),
        .i_position_index(pi), .o_common_line(com),
        .o_common_line_oe_n(com_oe_n), .o_segment_line_lower(lo),
        .o_segment_line_lower_oe_n(lo_oe_n), .o_segment_line_upper(hi),
        .o_segment_line_upper_oe_n(hi_oe_n));
    qsld_glass glass (.i_clock(i_clock), .i_common(com),
        .i_common_oe_n(com_oe_n), .i_segment({hi[7:0], lo[7:0]}),
        .i_segment_oe_n({hi_oe_n[7:0], lo_oe_n[7:0]}), .o_dark(dark));
    // bench copy of the glyph patterns
    function automatic logic [7:0] glyph_of(input logic [3:0] g);
        logic [7:0] t [10] = '{8'hEB, 8'h60, 8'hC7, 8'hE5, 8'h6C, 8'hAD,
            8'hAF, 8'hE0, 8'hEF, 8'hED};
        return (g < 4'hA) ? t[g] : 8'h00;
    endfunction
    // next value of the sixteen-bit random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // pin level comparison
    task automatic cmp_pin(input logic [31:0] got, input logic [31:0] ex);
        n_tests++;
        if (got !== ex) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask
    // timing comparison in clocks
    task automatic cmp_cnt(input int got, input int ex);
        n_tests++;
        if (got != ex) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask
    // hold reset eight clocks, clearing the expected memories
    task automatic reset_dut();
        @(negedge i_clock) i_rst_n = 1'b0;
        repeat (8) @(negedge i_clock);
        cmp_pin({com_oe_n, lo_oe_n[27:0]}, 32'hFFFFFFFF);
        for (int c = 0; c < 4; c++) exp_lo[c] = 32'h0;
        for (int c = 0; c < 4; c++) exp_hi[c] = 32'h0;
        prev_st = 3'h7;
        seen = 1'b0;
        since = 0;
        i_rst_n = 1'b1;
    endtask
    // one glyph write, noting where its crosses land
    task automatic put(input logic [3:0] p, input logic [3:0] g);
        logic [7:0] gl;
        logic [4:0] off;
        gl = glyph_of(g);
        off = {2'b00, p[1:0], 1'b0};
        @(negedge i_clock);
        wr = 1'b1;
        pi = p;
        gi = g;
        for (int c = 0; c < 4 && p < 4'h8; c++) begin
            // high nibble on the first pin, msb is common 3
            if (p < 4'h4) exp_lo[c][off +: 2] = {gl[c], gl[4 + c]};
            else exp_hi[c][off +: 2] = {gl[c], gl[4 + c]};
        end
    endtask
    // pin watcher: state order, tick spacing, common and segment levels
    always @(negedge i_clock) begin
        if (i_rst_n) begin
            since = since + 1;
            for (int c = 0; c < 4; c++)
                if (com_oe_n[c] === 1'b0) st = {c[1:0], com[c]};
            if (com_oe_n !== 4'hF && st !== prev_st) begin
                cmp_pin(st, 3'(prev_st + 3'h1));
                if (seen) cmp_cnt(since, TK);
                prev_st = st;
                seen = 1'b1;
                since = 0;
            end
            if (chk) begin
                ex_lo = st[0] ? ~exp_lo[st[2:1]] & MSK : exp_lo[st[2:1]];
                ex_hi = st[0] ? ~exp_hi[st[2:1]] & MSK : exp_hi[st[2:1]];
                cmp_pin(com_oe_n, {28'h0, ~(4'h1 << st[2:1])});
                cmp_pin(com[st[2:1]], st[0]);
                cmp_pin(lo, ex_lo);
                cmp_pin(hi, ex_hi);
                cmp_pin(lo_oe_n, ~MSK);
                cmp_pin(hi_oe_n, ~MSK);
            end
            // no tick for too long ends the run as a failure
            if (since > 3 * TK) begin
                err_total++;
                close_out();
            end
        end
    end
    // rounds of back-to-back writes, an ignored position, then watching
    initial begin
        reset_dut();
        for (int r = 0; r < 4; r++) begin
            for (int p = 0; p < 8; p++) begin
                lfsr = lfsr_next(lfsr);
                put(p[3:0], r < 2 ? 4'(r * 8 + p) : lfsr[3:0]);
            end
            put({1'b1, lfsr[6:4]}, 4'h8);
            @(negedge i_clock) wr = 1'b0;
            repeat (3 * TK) @(negedge i_clock);
            chk = 1'b1;
            repeat (16 * TK) @(negedge i_clock);
            chk = 1'b0;
            for (int c = 0; c < 4; c++)
                cmp_pin(dark[c], {exp_hi[c][7:0], exp_lo[c][7:0]});
            if (r == 2) reset_dut();
        end
        close_out();
    end
endmodule // qsld_driver_tb
